// file: hw/fts_top.sv
// fts_top: frame tick supervisor, backup tick and dead-time timer
// assumes spacecraft event pulses and clear strobes synchronous to clk
`timescale 1ns/10ps
module fts_top #(
	parameter int unsigned CW        = fts_pkg::CNT_W,
	parameter int unsigned BACKUP_TC = fts_pkg::BACKUP_DEF_CYC,
	parameter int unsigned DEAD_TC   = fts_pkg::DEAD_NOM_CYC
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// spacecraft events, one-cycle pulses
	input  wire logic                spacecraft_frame_tick,
	input  wire logic                spacecraft_dead_time_msg,
	// command-programmed terminal counts
	input  wire logic                backup_tc_load,
	input  wire logic [CW-1:0]       backup_tc_val,
	input  wire logic                dead_tc_load,
	input  wire logic [CW-1:0]       dead_tc_val,
	// software clear port
	input  wire fts_pkg::fts_clear_t clr,
	// status and interrupts
	output fts_pkg::fts_status_t     status,
	output logic                     frame_tick_irq,
	output logic                     dead_time_start_irq
);
	import fts_pkg::*;

	logic [CW-1:0] backup_tc_q;
	logic [CW-1:0] dead_tc_q;
	logic [CW-1:0] backup_cnt_q;
	logic [CW-1:0] dead_cnt_q;
	logic          dead_run_q;
	logic          backup_ovf;
	logic          tick_event;
	logic          dead_expire;
	logic          tick_irq_q;
	logic          dead_irq_q;
	fts_status_t   status_q;

	// ---------------------------------------------------------------
	// programmable terminal counts
	// ---------------------------------------------------------------
	// dead-time load is clamped to its documented window
	always_ff @(posedge clk) begin
		if (rst) begin
			backup_tc_q <= CW'(BACKUP_TC);
			dead_tc_q   <= CW'(DEAD_TC);
		end else begin
			if (backup_tc_load)
				backup_tc_q <= backup_tc_val;
			if (dead_tc_load) begin
				if (dead_tc_val < CW'(DEAD_MIN_CYC))
					dead_tc_q <= CW'(DEAD_MIN_CYC);
				else if (dead_tc_val > CW'(DEAD_MAX_CYC))
					dead_tc_q <= CW'(DEAD_MAX_CYC);
				else
					dead_tc_q <= dead_tc_val;
			end
		end
	end

	// ---------------------------------------------------------------
	// backup counter
	// ---------------------------------------------------------------
	assign backup_ovf = (backup_cnt_q >= backup_tc_q - CW'(1)) &&
		!spacecraft_frame_tick;
	assign tick_event = spacecraft_frame_tick | backup_ovf;

	// restarts on spacecraft tick and on its own overflow
	always_ff @(posedge clk) begin
		if (rst)
			backup_cnt_q <= '0;
		else if (tick_event)
			backup_cnt_q <= '0;
		else
			backup_cnt_q <= backup_cnt_q + CW'(1);
	end

	// ---------------------------------------------------------------
	// tick interrupt
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst)
			tick_irq_q <= 1'b0;
		else
			tick_irq_q <= tick_event;
	end

	// ---------------------------------------------------------------
	// dead-time timer
	// ---------------------------------------------------------------
	// the spacecraft message is deliberately not an input here
	assign dead_expire = dead_run_q &&
		(dead_cnt_q >= dead_tc_q - CW'(1)) && !tick_event;

	always_ff @(posedge clk) begin
		if (rst) begin
			dead_cnt_q <= '0;
			dead_run_q <= 1'b0;
		end else if (tick_event) begin
			dead_cnt_q <= '0;
			dead_run_q <= 1'b1;
		end else if (dead_expire) begin
			dead_cnt_q <= '0;
			dead_run_q <= 1'b0;
		end else if (dead_run_q) begin
			dead_cnt_q <= dead_cnt_q + CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			dead_irq_q <= 1'b0;
		else
			dead_irq_q <= dead_expire;
	end

	// ---------------------------------------------------------------
	// status flip-flops
	// ---------------------------------------------------------------
	// no read strobe exists, so reads cannot disturb these
	always_ff @(posedge clk) begin
		if (rst) begin
			status_q <= '0;
		end else begin
			if (spacecraft_frame_tick)
				status_q.tick_seen <= 1'b1;
			else if (clr.clr_tick)
				status_q.tick_seen <= 1'b0;
			if (spacecraft_dead_time_msg)
				status_q.dead_seen <= 1'b1;
			else if (clr.clr_dead)
				status_q.dead_seen <= 1'b0;
			if (backup_ovf)
				status_q.subst_seen <= 1'b1;
			else if (clr.clr_subst)
				status_q.subst_seen <= 1'b0;
			// active from dead-time timer expiry until the next tick event
			if (tick_event)
				status_q.dead_active <= 1'b0;
			else if (dead_expire)
				status_q.dead_active <= 1'b1;
		end
	end

	assign status              = status_q;
	assign frame_tick_irq      = tick_irq_q;
	assign dead_time_start_irq = dead_irq_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_dead_arm;
		tick_event ##1 dead_run_q;
	endsequence

	// overflow shows one cycle later as counter restart and interrupt together
	sequence s_backup_wrap;
		backup_ovf ##1 (frame_tick_irq && backup_cnt_q == '0);
	endsequence

	sequence s_dead_fire;
		dead_expire ##1 (dead_time_start_irq && !dead_run_q);
	endsequence

	chk_set_wins: assert property (@(posedge clk) disable iff (rst)
		spacecraft_frame_tick |=> status_q.tick_seen)
		else $error("tick status not set");
	chk_clear_only: assert property (@(posedge clk) disable iff (rst)
		(status_q.tick_seen && !clr.clr_tick) |=> status_q.tick_seen)
		else $error("tick status lost without clear");
	chk_dead_hold: assert property (@(posedge clk) disable iff (rst)
		(status_q.dead_seen && !clr.clr_dead) |=> status_q.dead_seen)
		else $error("dead status lost without clear");
	chk_backup_irq: assert property (@(posedge clk) disable iff (rst)
		backup_ovf |=> frame_tick_irq && status_q.subst_seen)
		else $error("overflow without irq or record");
	chk_no_subst: assert property (@(posedge clk) disable iff (rst)
		spacecraft_frame_tick |=> !backup_ovf)
		else $error("substitute tick right after spacecraft tick");
	chk_dead_cause: assert property (@(posedge clk) disable iff (rst)
		dead_time_start_irq |-> $past(dead_run_q) && !$past(tick_event))
		else $error("dead irq without timer");
	chk_msg_noirq: assert property (@(posedge clk) disable iff (rst)
		(spacecraft_dead_time_msg && !dead_run_q) |=> !dead_time_start_irq)
		else $error("message caused dead irq");
	chk_dead_restart: assert property (@(posedge clk) disable iff (rst)
		s_dead_arm |-> dead_cnt_q == '0)
		else $error("dead timer not restarted");
	chk_active_bit: assert property (@(posedge clk) disable iff (rst)
		dead_expire |=> status_q.dead_active)
		else $error("dead active bit not set");
	chk_tc_range: assert property (@(posedge clk) disable iff (rst)
		dead_tc_load |=> dead_tc_q >= CW'(DEAD_MIN_CYC) &&
			dead_tc_q <= CW'(DEAD_MAX_CYC))
		else $error("dead delay outside window");

	// ---------------------------------------------------------------
	// status flag checks
	// ---------------------------------------------------------------
	// every flag rises only for its own event, so software can trust it
	chk_dead_set: assert property (@(posedge clk) disable iff (rst)
		spacecraft_dead_time_msg |=> status_q.dead_seen)
		else $error("dead status not set");
	chk_subst_set: assert property (@(posedge clk) disable iff (rst)
		backup_ovf |=> status_q.subst_seen)
		else $error("substitute not recorded");
	chk_subst_hold: assert property (@(posedge clk) disable iff (rst)
		(status_q.subst_seen && !clr.clr_subst) |=> status_q.subst_seen)
		else $error("substitute record lost without clear");
	chk_tick_clear: assert property (@(posedge clk) disable iff (rst)
		(clr.clr_tick && !spacecraft_frame_tick) |=> !status_q.tick_seen)
		else $error("tick status not cleared");
	chk_dead_clear: assert property (@(posedge clk) disable iff (rst)
		(clr.clr_dead && !spacecraft_dead_time_msg) |=>
			!status_q.dead_seen)
		else $error("dead status not cleared");
	chk_subst_clear: assert property (@(posedge clk) disable iff (rst)
		(clr.clr_subst && !backup_ovf) |=> !status_q.subst_seen)
		else $error("substitute record not cleared");
	chk_tick_rise: assert property (@(posedge clk) disable iff (rst)
		$rose(status_q.tick_seen) |-> $past(spacecraft_frame_tick))
		else $error("tick status rose without tick");
	chk_dead_rise: assert property (@(posedge clk) disable iff (rst)
		$rose(status_q.dead_seen) |-> $past(spacecraft_dead_time_msg))
		else $error("dead status rose without message");
	chk_subst_rise: assert property (@(posedge clk) disable iff (rst)
		$rose(status_q.subst_seen) |-> $past(backup_ovf))
		else $error("substitute record rose without overflow");
	chk_dead_wins: assert property (@(posedge clk) disable iff (rst)
		(spacecraft_dead_time_msg && clr.clr_dead) |=>
			status_q.dead_seen)
		else $error("clear beat dead message");

	// ---------------------------------------------------------------
	// backup counter checks
	// ---------------------------------------------------------------
	chk_ovf_restart: assert property (@(posedge clk) disable iff (rst)
		backup_ovf |-> s_backup_wrap)
		else $error("overflow did not restart and interrupt");
	chk_tick_restart: assert property (@(posedge clk) disable iff (rst)
		spacecraft_frame_tick |=> backup_cnt_q == '0)
		else $error("tick did not restart backup counter");
	chk_cnt_step: assert property (@(posedge clk) disable iff (rst)
		!tick_event |=> backup_cnt_q == $past(backup_cnt_q) + CW'(1))
		else $error("backup counter skipped");
	chk_ovf_point: assert property (@(posedge clk) disable iff (rst)
		backup_ovf |-> backup_cnt_q >= backup_tc_q - CW'(1))
		else $error("overflow before terminal count");
	chk_irq_cause: assert property (@(posedge clk) disable iff (rst)
		frame_tick_irq |-> $past(tick_event))
		else $error("tick irq without tick event");
	chk_tc_hold: assert property (@(posedge clk) disable iff (rst)
		!backup_tc_load |=> $stable(backup_tc_q))
		else $error("backup count changed without load");
	chk_tc_load: assert property (@(posedge clk) disable iff (rst)
		backup_tc_load |=> backup_tc_q == $past(backup_tc_val))
		else $error("backup count not loaded");

	// ---------------------------------------------------------------
	// dead-time timer checks
	// ---------------------------------------------------------------
	// the timer is the only source, so a lost message never moves it
	chk_dead_run: assert property (@(posedge clk) disable iff (rst)
		tick_event |=> dead_run_q)
		else $error("dead timer not started");
	chk_dead_fires: assert property (@(posedge clk) disable iff (rst)
		dead_expire |-> s_dead_fire)
		else $error("dead timer expiry lost");
	chk_dead_idle: assert property (@(posedge clk) disable iff (rst)
		!dead_run_q |-> dead_cnt_q == '0)
		else $error("idle dead timer not at zero");
	chk_dead_step: assert property (@(posedge clk) disable iff (rst)
		(dead_run_q && !tick_event && !dead_expire) |=>
			dead_cnt_q == $past(dead_cnt_q) + CW'(1))
		else $error("dead timer skipped");
	chk_dead_alone: assert property (@(posedge clk) disable iff (rst)
		dead_time_start_irq |-> !frame_tick_irq)
		else $error("dead irq together with tick irq");
	chk_dtc_hold: assert property (@(posedge clk) disable iff (rst)
		!dead_tc_load |=> $stable(dead_tc_q))
		else $error("dead delay changed without load");
	chk_active_clr: assert property (@(posedge clk) disable iff (rst)
		tick_event |=> !status_q.dead_active)
		else $error("dead active bit not cleared");
	chk_active_keep: assert property (@(posedge clk) disable iff (rst)
		(status_q.dead_active && !tick_event) |=> status_q.dead_active)
		else $error("dead active bit dropped");
	chk_active_rise: assert property (@(posedge clk) disable iff (rst)
		$rose(status_q.dead_active) |-> $past(dead_expire))
		else $error("dead active bit rose without expiry");

endmodule // fts_top

// file: common/fts_pkg.sv
// fts_pkg: constants and carrier types for the frame tick supervisor
// assumes a 20 MHz processor clock
package fts_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned TICK_PERIOD_MS  = 125;
	localparam int unsigned DEAD_NOM_MS     = 120;
	localparam int unsigned DEAD_MIN_MS     = 114;
	localparam int unsigned DEAD_MAX_MS     = 130;
	// backup terminal count default: nominal period plus 1 ms margin
	localparam int unsigned BACKUP_MARGIN_MS = 1;
	localparam int unsigned BACKUP_DEF_CYC =
		(TICK_PERIOD_MS + BACKUP_MARGIN_MS) * (CLK_HZ / 1000);
	localparam int unsigned DEAD_NOM_CYC = DEAD_NOM_MS * (CLK_HZ / 1000);
	localparam int unsigned DEAD_MIN_CYC = DEAD_MIN_MS * (CLK_HZ / 1000);
	localparam int unsigned DEAD_MAX_CYC = DEAD_MAX_MS * (CLK_HZ / 1000);
	localparam int unsigned CNT_W = 22;

	// ---------------------------------------------------------------
	// status word layout
	// ---------------------------------------------------------------
	localparam int unsigned ST_TICK_BIT   = 0;
	localparam int unsigned ST_DEAD_BIT   = 1;
	localparam int unsigned ST_SUBST_BIT  = 2;
	localparam int unsigned ST_ACTIVE_BIT = 3;

	typedef struct packed {
		logic dead_active;
		logic subst_seen;
		logic dead_seen;
		logic tick_seen;
	} fts_status_t;

	typedef struct packed {
		logic clr_tick;
		logic clr_dead;
		logic clr_subst;
	} fts_clear_t;

endpackage

// file: tb/fts_sc_model.sv
// fts_sc_model: spacecraft bus controller issuing tick and dead-time msg
// assumes one-cycle requests from the bench, synchronous to clk
`timescale 1ns/10ps
module fts_sc_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// bench requests
	input  wire logic req,
	input  wire logic with_msg,
	// bus events toward the device
	output logic      tick,
	output logic      msg
);
	logic [3:0] gap_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			tick  <= 1'h0;
			msg   <= 1'h0;
			gap_q <= 4'h0;
		end else begin
			// tick opens the interval, message closes it well before the end
			tick  <= req;
			msg   <= (gap_q == 4'h1);
			if (req && with_msg)
				gap_q <= 4'h4;
			else if (gap_q != 4'h0)
				gap_q <= gap_q - 4'h1;
		end
	end
endmodule // fts_sc_model

// file: tb/tb_fts_top.sv
// tb_fts_top: self-checking bench for the frame tick supervisor
// assumes fts_top with shortened counts and the spacecraft model
`timescale 1ns/10ps
module tb_fts_top;
	import fts_pkg::*;
	localparam int BT = 20;
	localparam int DT = 12;
	logic             clk;
	logic             rst      = 1'h1;
	logic             req      = 1'h0;
	logic             with_msg = 1'h0;
	logic             bk_load  = 1'h0;
	logic [CNT_W-1:0] bk_val   = '0;
	logic             dt_load  = 1'h0;
	logic [CNT_W-1:0] dt_val   = '0;
	fts_clear_t       clr      = '0;
	logic             sc_tick, sc_msg, ft_irq, dt_irq;
	fts_status_t      status;
	int               errors, checked, n, irqs, base;

	// ---------------------------------------------------------------
	// clock and parts
	// ---------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (ft_irq === 1'h1) irqs++;
	fts_sc_model sc_u (.clk(clk), .rst(rst), .req(req),
		.with_msg(with_msg), .tick(sc_tick), .msg(sc_msg));
	// dead-time load clamps to the ms window; only probed at the very end
	fts_top #(.BACKUP_TC(BT), .DEAD_TC(DT)) dut_u (.clk(clk), .rst(rst),
		.spacecraft_frame_tick(sc_tick), .spacecraft_dead_time_msg(sc_msg),
		.backup_tc_load(bk_load), .backup_tc_val(bk_val),
		.dead_tc_load(dt_load), .dead_tc_val(dt_val), .clr(clr),
		.status(status), .frame_tick_irq(ft_irq),
		.dead_time_start_irq(dt_irq));

	task automatic chk_n(input int got, input int exp);
		checked++;
		if (got != exp) begin
			errors++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task automatic chk_st(input fts_status_t exp);
		checked++;
		if (status !== exp) begin
			errors++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, status, exp);
		end
	endtask
	task automatic send(input logic m);
		@(posedge clk);
		req <= 1'h1;
		with_msg <= m;
		@(posedge clk);
		req <= 1'h0;
	endtask
	// edges until the chosen interrupt shows, capped at lim
	task automatic lat(input logic dead, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while ((dead ? dt_irq : ft_irq) !== 1'h1 && n < lim);
	endtask
	task automatic summarize;
		$display("counts: checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#(50 * 3000);
		errors++;
		summarize;
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		#1 chk_st(4'h0);
		$display("test reset done");
		send(1'h1);
		lat(1'h0, 50);
		chk_n(n, 1);
		lat(1'h1, 50);
		chk_n(n, DT);
		@(posedge clk);
		#1 chk_st(4'hB);
		$display("test tick and dead time done");
		send(1'h0);
		clr <= 3'h4;
		@(posedge clk);
		clr <= 3'h2;
		@(posedge clk);
		clr <= 3'h0;
		repeat (4) @(posedge clk);
		#1 chk_st(4'h1);
		@(posedge clk);
		clr <= 3'h4;
		@(posedge clk);
		clr <= 3'h0;
		@(posedge clk);
		#1 chk_st(4'h0);
		$display("test clear port done");
		base = irqs;
		repeat (6) begin
			send(1'h0);
			repeat (12) @(posedge clk);
		end
		chk_n(irqs - base, 6);
		#1 chk_st(4'h1);
		$display("test nominal ticks done");
		send(1'h0);
		lat(1'h0, 50);
		chk_n(n, 1);
		lat(1'h0, 50);
		chk_n(n, BT);
		lat(1'h1, 50);
		chk_n(n, DT);
		@(posedge clk);
		#1 chk_st(4'hD);
		@(posedge clk);
		clr <= 3'h5;
		@(posedge clk);
		clr <= 3'h0;
		lat(1'h0, 50);
		chk_st(4'h4);
		send(1'h0);
		repeat (2) @(posedge clk);
		#1 chk_st(4'h5);
		$display("test substitute tick done");
		@(posedge clk);
		bk_val <= 22'h00_001E;
		bk_load <= 1'h1;
		@(posedge clk);
		bk_load <= 1'h0;
		send(1'h0);
		lat(1'h0, 50);
		lat(1'h0, 50);
		chk_n(n, 30);
		$display("test backup reload done");
		@(posedge clk);
		dt_val <= 22'h00_0000;
		dt_load <= 1'h1;
		@(posedge clk);
		dt_val <= 22'h3F_FFFF;
		@(posedge clk);
		dt_load <= 1'h0;
		repeat (2) @(posedge clk);
		#1 chk_st(4'h5);
		$display("test delay clamp done");
		summarize;
	end
endmodule // tb_fts_top
